// ===== inc/radio_panel_pkg.sv
// Purpose: Shared constants and types for the radio control panel state machine.
// Assumes: 20 MHz system clock; frequencies held as channel-name codes in kHz units.
// Notes: Frequencies are integer kHz (118000..155975); 8.33 kHz names use 5 kHz name steps.
package radio_panel_pkg;

	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned TX_LIMIT_S = 30;
	localparam int unsigned EDIT_IDLE_S = 5;
	localparam int unsigned LONG_PRESS_S = 2;
	localparam int unsigned INVERT_MS = 200;
	localparam int unsigned TX_LIMIT_CYC = TX_LIMIT_S * CLK_HZ;
	localparam int unsigned EDIT_IDLE_CYC = EDIT_IDLE_S * CLK_HZ;
	localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
	localparam int unsigned INVERT_CYC = INVERT_MS * (CLK_HZ / 1000);

	localparam int FREQ_W = 18;
	localparam logic [17:0] FREQ_MIN = 18'h1CCF0;
	localparam logic [17:0] FREQ_MAX = 18'h26147;
	localparam logic [17:0] FREQ_833_MAX = 18'h21728;
	localparam logic [17:0] STEP_MHZ = 18'h003E8;
	localparam logic [17:0] STEP_100K = 18'h00064;
	localparam logic [17:0] STEP_25K = 18'h00019;
	localparam logic [17:0] STEP_833 = 18'h00005;
	localparam logic [17:0] RESET_ACTIVE = 18'h1CCF0;
	localparam logic [17:0] RESET_PRESET = 18'h1CCF0;

	localparam int SLOTS = 20;
	localparam logic [4:0] SLOT_LAST = 5'h13;

	typedef enum logic [1:0] {
		SEL_STANDARD = 2'b00,
		SEL_DIRECT = 2'b01,
		SEL_CHANNEL = 2'b10
	} sel_mode_e;

	typedef enum logic [1:0] {
		GRP_MHZ = 2'b00,
		GRP_100K = 2'b01,
		GRP_FINE = 2'b10
	} digit_grp_e;

	typedef enum logic [1:0] {
		PWR_WAIT = 2'b00,
		PWR_RUN = 2'b01,
		PWR_FAIL = 2'b10
	} pwr_state_e;

	typedef struct packed {
		logic [17:0] top_freq;
		logic [17:0] bottom_freq;
		logic show_bottom_freq;
		logic [4:0] slot;
		logic slot_occupied;
		logic editing;
		logic [1:0] edit_group;
		logic tx_symbol;
		logic store_symbol;
		logic wait_msg;
		logic failure_msg;
		logic invert;
	} display_s;

endpackage : radio_panel_pkg

// ===== rtl/key_press_timer.sv
// Purpose: Synchronises one key and classifies each press as short or long.
// Assumes: Key active high, bounce filtered upstream or shorter than a clock.
// Notes: Long press fires once at the threshold while held; short fires on release.
module key_press_timer
	import radio_panel_pkg::*;
#(
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Raw key and classified events
	input wire logic key_raw,
	output logic key_level,
	output logic short_press,
	output logic long_press
);

	logic [2:0] sync_q;
	logic [31:0] held_q;
	logic long_done_q;

	// Three stages; change accepted once stages two and three agree
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q <= 3'h0;
			key_level <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], key_raw};
			if (sync_q[1] == sync_q[2]) begin
				key_level <= sync_q[2];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			held_q <= 32'h0;
			long_done_q <= 1'b0;
			short_press <= 1'b0;
			long_press <= 1'b0;
		end else begin
			short_press <= 1'b0;
			long_press <= 1'b0;
			if (key_level) begin
				if (held_q < LONG_CYC) begin
					held_q <= held_q + 32'h1;
				end
				if (held_q == LONG_CYC - 1 && !long_done_q) begin
					long_press <= 1'b1;
					long_done_q <= 1'b1;
				end
			end else begin
				if (held_q != 32'h0 && !long_done_q) begin
					short_press <= 1'b1;
				end
				held_q <= 32'h0;
				long_done_q <= 1'b0;
			end
		end
	end

endmodule : key_press_timer

// ===== rtl/radio_control_panel_fsm.sv
// Purpose: Control-panel state machine: start-up, receive/transmit, selection modes, editing, channel banks.
// Assumes: Encoder steps arrive as synchronous one-cycle pulses; keys and talk input are raw pins.
// Notes: Frequencies are kHz channel names; store procedure simplified to a direct save.
module radio_control_panel_fsm
	import radio_panel_pkg::*;
#(
	parameter int unsigned TX_LIMIT = TX_LIMIT_CYC,
	parameter int unsigned EDIT_IDLE = EDIT_IDLE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC,
	parameter int unsigned INVERT_LEN = INVERT_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Self-test status from the transceiver
	input wire logic power_on_self_test_busy,
	input wire logic power_on_self_test_error,
	// Operator controls (raw pins)
	input wire logic talk_request_input_n,
	input wire logic selection_cycle_key,
	input wire logic exchange_key,
	input wire logic store_key,
	input wire logic encoder_button,
	// Encoder rotation, synchronous one-cycle pulses
	input wire logic encoder_step_up,
	input wire logic encoder_step_down,
	// Configuration
	input wire logic spacing_mixed,
	// Transceiver control
	output logic transmit_enable,
	output logic [FREQ_W-1:0] tune_freq,
	output logic tx_timeout_failure,
	// Display state
	output display_s display,
	output logic vacant_slot_label,
	output logic occupied_slot_label
);

	logic talk_level;
	logic mode_short;
	logic xchg_short;
	logic store_short;
	logic enc_short;
	logic enc_long, enc_level, mode_long, xchg_long, store_long;

	pwr_state_e pwr_q;
	sel_mode_e mode_q;
	digit_grp_e grp_q;
	logic editing_q;
	logic tx_q;
	logic tx_lock_q;
	logic fail_q;
	logic [31:0] tx_cnt_q;
	logic [31:0] idle_cnt_q;
	logic [31:0] inv_cnt_q;
	logic [FREQ_W-1:0] active_q;
	logic [FREQ_W-1:0] preset_q;
	logic [FREQ_W-1:0] saved_active_q;
	logic [FREQ_W-1:0] saved_preset_q;
	logic [4:0] slot_q;
	logic [4:0] last_slot_q;

	// One bank per spacing mode; bank 1 is mixed spacing
	logic [FREQ_W-1:0] bank_freq_q [2][SLOTS];
	logic bank_used_q [2][SLOTS];

	logic running;
	logic bank;
	logic any_used;
	logic [4:0] first_vacant;
	logic vacant_found;
	logic slot_used;
	logic [FREQ_W-1:0] slot_freq;
	logic reject;
	logic step_any;
	logic [FREQ_W-1:0] edit_base;
	logic [FREQ_W-1:0] edit_step;
	logic [FREQ_W-1:0] edit_next;
	logic [4:0] slot_next;

	// Talk input is active low; synchronised and classified like a key
	key_press_timer #(.LONG_CYC(LONG_CYC)) u_talk (
		.sys_clk(sys_clk), .rst_n(rst_n), .key_raw(~talk_request_input_n),
		.key_level(talk_level), .short_press(), .long_press()
	);
	key_press_timer #(.LONG_CYC(LONG_CYC)) u_mode (
		.sys_clk(sys_clk), .rst_n(rst_n), .key_raw(selection_cycle_key),
		.key_level(), .short_press(mode_short), .long_press(mode_long)
	);
	key_press_timer #(.LONG_CYC(LONG_CYC)) u_xchg (
		.sys_clk(sys_clk), .rst_n(rst_n), .key_raw(exchange_key),
		.key_level(), .short_press(xchg_short), .long_press(xchg_long)
	);
	key_press_timer #(.LONG_CYC(LONG_CYC)) u_store (
		.sys_clk(sys_clk), .rst_n(rst_n), .key_raw(store_key),
		.key_level(), .short_press(store_short), .long_press(store_long)
	);
	key_press_timer #(.LONG_CYC(LONG_CYC)) u_enc (
		.sys_clk(sys_clk), .rst_n(rst_n), .key_raw(encoder_button),
		.key_level(enc_level), .short_press(enc_short), .long_press(enc_long)
	);

	assign running = (pwr_q == PWR_RUN);
	assign bank = spacing_mixed;
	assign step_any = encoder_step_up ^ encoder_step_down;

	always_comb begin
		any_used = 1'b0;
		first_vacant = 5'h0;
		vacant_found = 1'b0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (bank_used_q[bank][i]) begin
				any_used = 1'b1;
			end else begin
				first_vacant = 5'(i);
				vacant_found = 1'b1;
			end
		end
	end

	// 8.33 kHz names are not multiples of 25 kHz; hide them in 25 kHz spacing
	assign slot_freq = bank_freq_q[bank][slot_q];
	assign slot_used = bank_used_q[bank][slot_q]
		&& (spacing_mixed || (slot_freq % STEP_25K) == 18'h0);

	// Edit target and step size
	always_comb begin
		edit_base = (mode_q == SEL_DIRECT) ? active_q : preset_q;
		case (grp_q)
			GRP_MHZ: edit_step = STEP_MHZ;
			GRP_100K: edit_step = STEP_100K;
			GRP_FINE: edit_step = (spacing_mixed && edit_base < FREQ_833_MAX) ? STEP_833 : STEP_25K;
			default: edit_step = STEP_MHZ;
		endcase
		edit_next = edit_base;
		if (encoder_step_up) begin
			edit_next = (edit_base + edit_step > FREQ_MAX) ? FREQ_MAX : edit_base + edit_step;
		end else if (encoder_step_down) begin
			edit_next = (edit_base < FREQ_MIN + edit_step) ? FREQ_MIN : edit_base - edit_step;
		end
		slot_next = slot_q;
		if (encoder_step_up) begin
			slot_next = (slot_q == SLOT_LAST) ? 5'h0 : slot_q + 5'h1;
		end else if (encoder_step_down) begin
			slot_next = (slot_q == 5'h0) ? SLOT_LAST : slot_q - 5'h1;
		end
	end

	// Rejected actions: blocked in transmit, wrong mode, a store with no vacant slot, or a long press on a key without long function
	always_comb begin
		reject = 1'b0;
		if (running && tx_q) begin
			if (mode_short || xchg_short) begin
				reject = 1'b1;
			end
			if (step_any && editing_q && mode_q != SEL_STANDARD) begin
				reject = 1'b1;
			end
			if (store_short && mode_q == SEL_CHANNEL) begin
				reject = 1'b1;
			end
		end
		if (running && store_short && mode_q != SEL_CHANNEL && !vacant_found) begin
			reject = 1'b1;
		end
		if (running && ((xchg_short && mode_q != SEL_STANDARD) || mode_long || xchg_long || store_long)) begin
			reject = 1'b1;
		end
	end

	// Power-on sequence
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= PWR_WAIT;
		end else if (pwr_q == PWR_WAIT && !power_on_self_test_busy) begin
			pwr_q <= power_on_self_test_error ? PWR_FAIL : PWR_RUN;
		end
	end

	// Transmit control and 30 s limit; a new press is needed after a timeout
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_q <= 1'b0;
			tx_lock_q <= 1'b0;
			tx_cnt_q <= 32'h0;
			fail_q <= 1'b0;
		end else if (!running || !talk_level) begin
			tx_q <= 1'b0;
			tx_lock_q <= 1'b0;
			tx_cnt_q <= 32'h0;
		end else if (tx_q && tx_cnt_q == TX_LIMIT - 1) begin
			tx_q <= 1'b0;
			tx_lock_q <= 1'b1;
			fail_q <= 1'b1;
		end else if (!tx_lock_q) begin
			tx_q <= 1'b1;
			tx_cnt_q <= tx_cnt_q + 32'h1;
		end
	end

	// Selection mode cycling
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= SEL_STANDARD;
		end else if (running && mode_short && !tx_q) begin
			case (mode_q)
				SEL_STANDARD: mode_q <= SEL_DIRECT;
				SEL_DIRECT: mode_q <= SEL_CHANNEL;
				SEL_CHANNEL: mode_q <= SEL_STANDARD;
				default: mode_q <= SEL_STANDARD;
			endcase
		end
	end

	// Edit session: group selection and idle/long-press exit
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			editing_q <= 1'b0;
			grp_q <= GRP_MHZ;
			idle_cnt_q <= 32'h0;
		end else if (!running || (mode_short && !tx_q)) begin
			editing_q <= 1'b0;
			grp_q <= GRP_MHZ;
			idle_cnt_q <= 32'h0;
		end else if (enc_long || (editing_q && idle_cnt_q == EDIT_IDLE - 1)) begin
			editing_q <= 1'b0;
			grp_q <= GRP_MHZ;
			idle_cnt_q <= 32'h0;
		end else if (enc_short) begin
			idle_cnt_q <= 32'h0;
			if (!editing_q || mode_q == SEL_CHANNEL) begin
				editing_q <= 1'b1;
				grp_q <= GRP_MHZ;
			end else begin
				case (grp_q)
					GRP_MHZ: grp_q <= GRP_100K;
					GRP_100K: grp_q <= GRP_FINE;
					GRP_FINE: grp_q <= GRP_MHZ;
					default: grp_q <= GRP_MHZ;
				endcase
			end
		end else if (editing_q) begin
			idle_cnt_q <= (step_any || enc_level) ? 32'h0 : idle_cnt_q + 32'h1;
		end
	end

	// Active and preset frequencies
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= RESET_ACTIVE;
			preset_q <= RESET_PRESET;
			saved_active_q <= RESET_ACTIVE;
			saved_preset_q <= RESET_PRESET;
		end else if (running) begin
			if (mode_short && !tx_q) begin
				if (mode_q == SEL_DIRECT) begin
					saved_active_q <= active_q;
					saved_preset_q <= preset_q;
					if (bank_used_q[bank][last_slot_q] && (spacing_mixed || bank_freq_q[bank][last_slot_q] % STEP_25K == 18'h0)) begin
						active_q <= bank_freq_q[bank][last_slot_q];
					end
				end else if (mode_q == SEL_CHANNEL) begin
					active_q <= saved_active_q;
					preset_q <= saved_preset_q;
				end
			end else if (xchg_short && !tx_q && mode_q == SEL_STANDARD) begin
				active_q <= preset_q;
				preset_q <= active_q;
			end else if (editing_q && step_any) begin
				if (mode_q == SEL_STANDARD) begin
					preset_q <= edit_next;
				end else if (mode_q == SEL_DIRECT && !tx_q) begin
					active_q <= edit_next;
				end else if (mode_q == SEL_CHANNEL && !tx_q && bank_used_q[bank][slot_next]
					&& (spacing_mixed || bank_freq_q[bank][slot_next] % STEP_25K == 18'h0)) begin
					active_q <= bank_freq_q[bank][slot_next];
				end
			end
		end
	end

	// Slot selection, most recent slot remembered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_q <= 5'h0;
			last_slot_q <= 5'h0;
		end else if (running) begin
			if (mode_short && !tx_q && mode_q == SEL_DIRECT) begin
				slot_q <= any_used ? last_slot_q : 5'h0;
			end else if (mode_q == SEL_CHANNEL && editing_q && step_any && !tx_q) begin
				slot_q <= slot_next;
				last_slot_q <= slot_next;
			end else if (store_short && mode_q != SEL_CHANNEL && vacant_found) begin
				last_slot_q <= first_vacant;
			end
		end
	end

	// Channel banks: store active frequency into first vacant slot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < SLOTS; i++) begin
					bank_freq_q[b][i] <= RESET_ACTIVE;
					bank_used_q[b][i] <= 1'b0;
				end
			end
		end else if (running && store_short && mode_q != SEL_CHANNEL && vacant_found) begin
			bank_freq_q[bank][first_vacant] <= active_q;
			bank_used_q[bank][first_vacant] <= 1'b1;
		end
	end

	// Brief full-display inversion as feedback
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			inv_cnt_q <= 32'h0;
		end else if (reject) begin
			inv_cnt_q <= INVERT_LEN;
		end else if (inv_cnt_q != 32'h0) begin
			inv_cnt_q <= inv_cnt_q - 32'h1;
		end
	end

	// Outputs from flip-flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_enable <= 1'b0;
			tune_freq <= RESET_ACTIVE;
			tx_timeout_failure <= 1'b0;
			display <= '0;
			vacant_slot_label <= 1'b0;
			occupied_slot_label <= 1'b0;
		end else begin
			transmit_enable <= tx_q;
			tune_freq <= active_q;
			tx_timeout_failure <= fail_q;
			display.top_freq <= active_q;
			display.bottom_freq <= preset_q;
			display.show_bottom_freq <= (mode_q == SEL_STANDARD);
			display.slot <= slot_q;
			display.slot_occupied <= slot_used;
			display.editing <= editing_q;
			display.edit_group <= grp_q;
			display.tx_symbol <= tx_q;
			display.store_symbol <= running && store_short;
			display.wait_msg <= (pwr_q == PWR_WAIT);
			display.failure_msg <= (pwr_q == PWR_FAIL) || fail_q;
			display.invert <= (inv_cnt_q != 32'h0);
			occupied_slot_label <= (mode_q == SEL_CHANNEL) && slot_used;
			vacant_slot_label <= (mode_q == SEL_CHANNEL) && !slot_used;
		end
	end

endmodule : radio_control_panel_fsm

// ===== bench/radio_panel_properties.sv
// Purpose: Port-level properties of the radio control panel state machine.
// Assumes: One clock domain; parameters mirror the bound design instance.
// Notes: Margins of a few cycles cover the talk and key synchronisers.
module radio_panel_properties
	import radio_panel_pkg::*;
#(
	parameter int unsigned TX_LIMIT = TX_LIMIT_CYC,
	parameter int unsigned EDIT_IDLE = EDIT_IDLE_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Watched inputs
	input wire logic power_on_self_test_busy,
	input wire logic power_on_self_test_error,
	input wire logic talk_request_input_n,
	input wire logic selection_cycle_key,
	input wire logic exchange_key,
	input wire logic store_key,
	input wire logic encoder_button,
	input wire logic encoder_step_up,
	input wire logic encoder_step_down,
	// Watched outputs
	input wire logic transmit_enable,
	input wire logic [FREQ_W-1:0] tune_freq,
	input wire logic tx_timeout_failure,
	input wire display_s display,
	input wire logic vacant_slot_label,
	input wire logic occupied_slot_label
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	int unsigned tx_cnt_q;
	int unsigned idle_cnt_q;
	logic any_input;
	assign any_input = encoder_button | encoder_step_up | encoder_step_down | selection_cycle_key | exchange_key
		| store_key;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt_q <= 0;
		end else begin
			tx_cnt_q <= transmit_enable ? tx_cnt_q + 1 : 0;
		end
	end
	// Any key activity restarts the idle count, even keys the design ignores
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_q <= 0;
		end else begin
			idle_cnt_q <= (display.editing && !any_input) ? idle_cnt_q + 1 : 0;
		end
	end
	AST_RX_IDLE: assert property (talk_request_input_n [*7] |-> !transmit_enable)
		else $error("transmit while talk request inactive");
	AST_TX_ON: assert property (($fell(talk_request_input_n) && !tx_timeout_failure && !display.wait_msg
		&& !display.failure_msg) ##1 (!talk_request_input_n) [*7] |-> transmit_enable)
		else $error("talk request did not start transmit");
	AST_TX_SYMBOL: assert property ($rose(transmit_enable) |-> ##[0:2] display.tx_symbol)
		else $error("transmit indicator missing");
	AST_TX_LIMIT: assert property (tx_cnt_q <= TX_LIMIT + 2)
		else $error("transmit exceeded limit");
	AST_FAIL_CAUSE: assert property ($rose(tx_timeout_failure) |->
		!transmit_enable && $past(tx_cnt_q) + 2 >= TX_LIMIT)
		else $error("failure raised without timeout or transmit kept");
	// Sticky until reset; a fresh talk press may transmit again
	AST_FAIL_STICKY: assert property (tx_timeout_failure |=> tx_timeout_failure)
		else $error("failure flag dropped");
	AST_TX_STABLE: assert property (transmit_enable [*3] |-> $stable(tune_freq))
		else $error("tuning changed during transmit");
	AST_EDIT_IDLE: assert property (idle_cnt_q <= EDIT_IDLE + 8)
		else $error("editing outlived idle timeout");
	AST_GROUP_START: assert property ($rose(display.editing) |-> display.edit_group == GRP_MHZ)
		else $error("editing did not start at MHz group");
	AST_LABELS: assert property (!(vacant_slot_label && occupied_slot_label))
		else $error("slot shown vacant and occupied");
	AST_RANGE: assert property (tune_freq >= FREQ_MIN && tune_freq <= FREQ_MAX)
		else $error("tuning outside band");
	AST_SELFTEST: assert property ((display.wait_msg && !power_on_self_test_busy) |-> ##[1:3]
		(!display.wait_msg && display.failure_msg == power_on_self_test_error))
		else $error("self-test result not shown");
	COV_TIMEOUT: cover property ($rose(tx_timeout_failure));
	COV_OCCUPIED: cover property ($rose(occupied_slot_label));
	COV_INVERT: cover property ($rose(display.invert));
endmodule : radio_panel_properties

bind radio_control_panel_fsm radio_panel_properties #(.TX_LIMIT(TX_LIMIT), .EDIT_IDLE(EDIT_IDLE))
	radio_panel_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .power_on_self_test_busy(power_on_self_test_busy),
	.power_on_self_test_error(power_on_self_test_error), .talk_request_input_n(talk_request_input_n),
	.selection_cycle_key(selection_cycle_key), .exchange_key(exchange_key), .store_key(store_key),
	.encoder_button(encoder_button), .encoder_step_up(encoder_step_up), .encoder_step_down(encoder_step_down),
	.transmit_enable(transmit_enable), .tune_freq(tune_freq), .tx_timeout_failure(tx_timeout_failure),
	.display(display), .vacant_slot_label(vacant_slot_label), .occupied_slot_label(occupied_slot_label));

// ===== bench/panel_operator.sv
// Purpose: Operator and transceiver side: keys, encoder, talk pin and self-test status.
// Assumes: Driven 1 ns after the rising edge; self-test restarts with each reset.
// Notes: Key index 0 mode, 1 exchange, 2 store, 3 encoder button.
module panel_operator #(
	parameter int TEST_CYC = 40,
	parameter logic TEST_ERR = 1'b0
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Self-test status
	output logic busy,
	output logic error,
	// Operator pins
	output logic talk_n,
	output logic [3:0] keys,
	output logic step_up,
	output logic step_down
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_q;
	initial begin
		talk_n = 1'b1;
		error = TEST_ERR;
		keys = 4'h0;
		step_up = 1'b0;
		step_down = 1'b0;
	end
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
		end else if (cnt_q < TEST_CYC) begin
			cnt_q <= cnt_q + 1;
		end
	end
	assign busy = cnt_q < TEST_CYC;
	task automatic fail_test(input logic e);
		error = e;
	endtask : fail_test
	// Release wait leaves room for the synchroniser and the short-press event
	task automatic press(input int k, input int n);
		@(posedge sys_clk);
		#1 keys[k] = 1'b1;
		repeat (n) @(posedge sys_clk);
		#1 keys[k] = 1'b0;
		repeat (8) @(posedge sys_clk);
		#2;
	endtask : press
	task automatic step(input logic up);
		@(posedge sys_clk);
		#1 step_up = up;
		step_down = !up;
		@(posedge sys_clk);
		#1 step_up = 1'b0;
		step_down = 1'b0;
		repeat (3) @(posedge sys_clk);
		#2;
	endtask : step
	task automatic talk(input logic v);
		@(posedge sys_clk);
		#1 talk_n = v;
	endtask : talk
endmodule : panel_operator

// ===== bench/radio_control_panel_fsm_tb.sv
// Purpose: Directed test of modes, editing, exchange, store and transmit limit.
// Assumes: Shortened counts: limit 200, idle 100, long press 20, inversion 5 cycles.
// Notes: Mixed spacing is switched on once for a fine step; a mid-run reset covers a failed self-test.
module radio_control_panel_fsm_tb
	import radio_panel_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic spacing_mixed = 1'b0;
	logic busy, err, talk_n, up, dn, tx_en, tx_fail, vac, occ;
	logic inv_seen = 1'b0;
	logic sto_seen = 1'b0;
	logic [3:0] keys;
	logic [FREQ_W-1:0] tune;
	display_s disp;
	int n_fail = 0;
	int compares = 0;
	always #25 sys_clk = ~sys_clk;
	panel_operator panel_operator_i (.sys_clk(sys_clk), .rst_n(rst_n), .busy(busy), .error(err), .talk_n(talk_n),
		.keys(keys), .step_up(up), .step_down(dn));
	radio_control_panel_fsm #(.TX_LIMIT(200), .EDIT_IDLE(100), .LONG_CYC(20), .INVERT_LEN(5))
		radio_control_panel_fsm_i (.sys_clk(sys_clk), .rst_n(rst_n), .power_on_self_test_busy(busy),
		.power_on_self_test_error(err), .talk_request_input_n(talk_n), .selection_cycle_key(keys[0]),
		.exchange_key(keys[1]), .store_key(keys[2]), .encoder_button(keys[3]), .encoder_step_up(up),
		.encoder_step_down(dn), .spacing_mixed(spacing_mixed), .transmit_enable(tx_en), .tune_freq(tune),
		.tx_timeout_failure(tx_fail), .display(disp), .vacant_slot_label(vac), .occupied_slot_label(occ));
	// Inversion lasts only a few cycles, so it is latched here
	always @(posedge sys_clk) begin
		if (disp.invert === 1'b1) begin
			inv_seen <= 1'b1;
		end
		if (disp.store_symbol === 1'b1) begin
			sto_seen <= 1'b1;
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : cyc
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		cyc(5);
		check(disp.wait_msg, 1'b1);
		cyc(50);
		check({disp.wait_msg, disp.failure_msg}, 2'h0);
		check(tx_en, 1'b0);
		check(tune, 18'h1CCF0);
		check(disp.show_bottom_freq, 1'b1);
		panel_operator_i.press(3, 3);
		check({disp.editing, disp.edit_group}, 3'h4);
		panel_operator_i.step(1'b1);
		check(disp.bottom_freq, 18'h1D0D8);
		check(tune, 18'h1CCF0);
		panel_operator_i.press(3, 3);
		check({disp.editing, disp.edit_group}, 3'h5);
		panel_operator_i.step(1'b0);
		check(disp.bottom_freq, 18'h1D074);
		panel_operator_i.press(3, 3);
		check({disp.editing, disp.edit_group}, 3'h6);
		panel_operator_i.step(1'b1);
		check(disp.bottom_freq, 18'h1D08D);
		panel_operator_i.press(3, 3);
		check({disp.editing, disp.edit_group}, 3'h4);
		cyc(120);
		check(disp.editing, 1'b0);
		panel_operator_i.press(1, 3);
		check({tune, disp.bottom_freq}, {18'h1D08D, 18'h1CCF0});
		panel_operator_i.press(0, 3);
		check({disp.show_bottom_freq, tune}, {1'b0, 18'h1D08D});
		panel_operator_i.press(3, 3);
		panel_operator_i.step(1'b1);
		check(tune, 18'h1D475);
		panel_operator_i.press(3, 30);
		check(disp.editing, 1'b0);
		panel_operator_i.press(2, 3);
		panel_operator_i.press(0, 3);
		check({occ, vac, disp.slot}, 7'h40);
		check(disp.top_freq, 18'h1D475);
		panel_operator_i.press(0, 3);
		check({tune, disp.bottom_freq}, {18'h1D475, 18'h1CCF0});
		check({disp.show_bottom_freq, occ}, 2'h2);
		inv_seen = 1'b0;
		panel_operator_i.press(0, 30);
		check({inv_seen, disp.show_bottom_freq}, 2'h3);
		@(posedge sys_clk) #1 spacing_mixed = 1'b1;
		panel_operator_i.press(0, 3);
		panel_operator_i.press(3, 3);
		panel_operator_i.press(3, 3);
		panel_operator_i.press(3, 3);
		panel_operator_i.step(1'b1);
		check(tune, 18'h1D47A);
		@(posedge sys_clk) #1 spacing_mixed = 1'b0;
		sto_seen = 1'b0;
		panel_operator_i.press(2, 3);
		check(sto_seen, 1'b1);
		panel_operator_i.step(1'b1);
		check(tune, 18'h1D493);
		panel_operator_i.press(0, 3);
		check({occ, vac, disp.slot, tune}, {7'h21, 18'h1D493});
		panel_operator_i.press(0, 3);
		panel_operator_i.talk(1'b0);
		cyc(10);
		check({tx_en, disp.tx_symbol}, 2'h3);
		inv_seen = 1'b0;
		panel_operator_i.press(1, 3);
		check(inv_seen, 1'b1);
		check(tune, 18'h1D493);
		panel_operator_i.press(0, 3);
		check(disp.show_bottom_freq, 1'b1);
		cyc(200);
		check({tx_en, tx_fail}, 2'h1);
		panel_operator_i.talk(1'b1);
		cyc(10);
		check(tx_en, 1'b0);
		panel_operator_i.talk(1'b0);
		cyc(10);
		check({tx_en, tx_fail}, 2'h3);
		panel_operator_i.talk(1'b1);
		cyc(10);
		check(tx_en, 1'b0);
		@(posedge sys_clk) #1 rst_n = 1'b0;
		panel_operator_i.fail_test(1'b1);
		cyc(3);
		check({tx_fail, disp.failure_msg, tune}, {2'h0, 18'h1CCF0});
		@(posedge sys_clk) #1 rst_n = 1'b1;
		cyc(5);
		check(disp.wait_msg, 1'b1);
		cyc(50);
		check({disp.wait_msg, disp.failure_msg}, 2'h1);
		test_done();
	end
endmodule : radio_control_panel_fsm_tb
